// >>> hub_pp_pkg.sv
// Shared constants and types for the hub port power control block.
// Assumes a single 100 MHz core clock and a plain register port.
package hub_pp_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int NPORTS = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MS_W   = 14;

   // ------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CHG_EN = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CFG    = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_RETRY  = 8'h0C;

   localparam logic [NPORTS:1] CHG_EN_RESET = 4'h0;
   localparam logic [3:0]      CFG_RESET    = 4'h8;

   // Status word field positions.
   localparam int STAT_PWR_POS  = 0;
   localparam int STAT_HOLD_POS = 8;
   localparam int STAT_DCP_POS  = 16;
   localparam int STAT_SUSP_BIT = 24;
   localparam int STAT_VBUS_BIT = 25;
   localparam int STAT_INIT_BIT = 26;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

   localparam logic [MS_W-1:0] RETRY_SHORT_MS = 14'h03E8;
   localparam logic [MS_W-1:0] RETRY_LONG_MS  = 14'h2710;
   localparam logic [MS_W-1:0] RETRY_CLEAN_MS = 14'h03E8;
   localparam logic [1:0]      RETRY_FAST_MAX = 2'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic susp_en;
      logic swap_sel;
      logic swap_en;
      logic indiv;
   } cfg_t;

   typedef enum logic [1:0] {
      SLOT_OFF  = 2'b00,
      SLOT_ON   = 2'b01,
      SLOT_HOLD = 2'b11
   } slot_state_t;

endpackage

// >>> port_power_slot.sv
// One downstream port's power state and over-current retry timer.
// Assumes a one-cycle millisecond tick and a fault input already qualified.
module port_power_slot #(
   parameter int MS_W = hub_pp_pkg::MS_W
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Timebase and control
   input  wire logic        tick_in,
   input  wire logic        request_in,
   input  wire logic        release_in,
   input  wire logic        dcp_in,
   input  wire logic        fault_in,
   // Port state
   output logic             power_out,
   output logic             hold_out,
   output logic [1:0]       attempts_out
);

   hub_pp_pkg::slot_state_t state;
   hub_pp_pkg::slot_state_t next_state;
   logic [MS_W-1:0]         ms_count;
   logic [MS_W-1:0]         next_ms_count;
   logic [1:0]              attempts;
   logic [1:0]              next_attempts;
   logic [MS_W-1:0]         interval;
   logic                    last_ms;
   logic                    clean_done;

   // ------------------------------------------------------------
   // Retry interval selection
   // ------------------------------------------------------------
   assign interval   = (attempts == hub_pp_pkg::RETRY_FAST_MAX) ?
                       MS_W'(hub_pp_pkg::RETRY_LONG_MS) :
                       MS_W'(hub_pp_pkg::RETRY_SHORT_MS);
   assign last_ms    = ms_count == interval - MS_W'(1);
   assign clean_done = ms_count == MS_W'(hub_pp_pkg::RETRY_CLEAN_MS) - MS_W'(1);

   assign power_out    = state == hub_pp_pkg::SLOT_ON;
   assign hold_out     = state == hub_pp_pkg::SLOT_HOLD;
   assign attempts_out = attempts;

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_ms_count = ms_count;
      next_attempts = attempts;
      unique case (state)
         hub_pp_pkg::SLOT_OFF: begin
            next_ms_count = '0;
            next_attempts = '0;
            if (request_in && !fault_in) begin
               next_state = hub_pp_pkg::SLOT_ON;
            end
         end
         hub_pp_pkg::SLOT_ON: begin
            if (!request_in) begin
               next_state = hub_pp_pkg::SLOT_OFF;
            end else if (fault_in) begin
               next_state    = hub_pp_pkg::SLOT_HOLD;
               next_ms_count = '0;
            end else if (tick_in) begin
               if (clean_done) begin
                  next_attempts = '0;
               end else begin
                  next_ms_count = ms_count + MS_W'(1);
               end
            end
         end
         hub_pp_pkg::SLOT_HOLD: begin
            if (!dcp_in) begin
               // The host owns recovery: the port stays off until it drops power.
               if (release_in || !request_in) begin
                  next_state = hub_pp_pkg::SLOT_OFF;
               end
            end else if (tick_in) begin
               if (last_ms) begin
                  // A ganged fault elsewhere defers the retry by a tick.
                  if (!fault_in) begin
                     next_state    = hub_pp_pkg::SLOT_ON;
                     next_ms_count = '0;
                     if (attempts != hub_pp_pkg::RETRY_FAST_MAX) begin
                        next_attempts = attempts + 2'h1;
                     end
                  end
               end else begin
                  next_ms_count = ms_count + MS_W'(1);
               end
            end
         end
         default: begin
            next_state = hub_pp_pkg::SLOT_OFF;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state    <= hub_pp_pkg::SLOT_OFF;
         ms_count <= '0;
         attempts <= '0;
      end else begin
         state    <= next_state;
         ms_count <= next_ms_count;
         attempts <= next_attempts;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking slot_cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   AST_RETRY_WAIT: assert property (
      state == hub_pp_pkg::SLOT_HOLD && dcp_in && !(tick_in && last_ms)
      |=> state != hub_pp_pkg::SLOT_ON)
      else $error("Charging port re-enabled before its off interval ended.");

   AST_RETRY_BACK: assert property (
      state == hub_pp_pkg::SLOT_HOLD && dcp_in && tick_in && last_ms && !fault_in
      |=> power_out)
      else $error("Charging port not re-enabled after its off interval.");

   AST_LONG_AFTER3: assert property (
      state == hub_pp_pkg::SLOT_HOLD && dcp_in && attempts == 2'h3 && tick_in
      && ms_count == hub_pp_pkg::RETRY_SHORT_MS - 14'h0001
      |=> state == hub_pp_pkg::SLOT_HOLD)
      else $error("Short retry interval used after three attempts.");

   AST_CLEAN_CLEAR: assert property (
      state == hub_pp_pkg::SLOT_ON && request_in && !fault_in && tick_in
      && clean_done |=> attempts == 2'h0)
      else $error("Retry count not cleared after a clean second.");

endmodule

// >>> hub_port_power_control.sv
// Downstream port power enables, over-current handling, role swap pin
// remapping and the suspend level output of the hub.
// Assumes hub core status inputs on clock_in; all pin inputs are asynchronous.
//
// How it works
// - One charging enable bit per port; bit 1 is port 1.
// - A charging enable also sets that port's power request.
// - Charging ports power up once hardware init finishes, no host needed.
// - Ganged switching: any over-current removes power from every port.
// - Individual switching: only the faulting port loses power.
// - Dedicated charging port: off one second, back on, three times.
// - After three retries keep retrying forever with ten-second off time.
// - Host-governed ports only latch faults while powered; host clears them.
// - Role swap uses a feature enable bit and a swap select bit.
// - Only physical port 1 swaps with upstream; others keep their numbers.
// - Swap enabled, select clear: port 1 pin is combined enable and sense.
// - Swap enabled, select clear: suspend pin driven low.
// - Swap enabled and selected: upstream bus-power detect ignored.
// - Swap enabled and selected: port 1 pin forced high.
// - Swap enabled and selected: suspend pin is port 1 enable and sense.
// - Suspend output reflects whole-hub suspend only, not selective suspend.
// - Suspend output is a plain level, nothing to acknowledge.
// - Suspend asserted while suspended or unconfigured.
// - Port charging type fixed after power-up configuration.
//
// The plain strobed port and the address map were left to the implementer.
module hub_port_power_control #(
   parameter int NPORTS      = hub_pp_pkg::NPORTS,
   parameter int TICK_CYCLES = hub_pp_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                          clock_in,
   input  wire logic                          rst_in,
   // Register port
   input  wire hub_pp_pkg::reg_req_t          reg_req_in,
   output logic [hub_pp_pkg::DATA_W-1:0]      read_data_out,
   // Hub core status
   input  wire logic                          hw_init_done_in,
   input  wire logic                          host_connected_in,
   input  wire logic                          hub_suspended_in,
   input  wire logic                          hub_configured_in,
   input  wire logic [NPORTS:1]               host_port_power_in,
   // Downstream power switches, ports 2 and up
   output logic [NPORTS:2]                    port_power_enable_out,
   input  wire logic [NPORTS:2]               overcurrent_sense_in_n,
   // Port 1 power switch, two-way in combined mode
   output logic                               port1_power_enable_out,
   output logic                               port1_power_oe_out,
   input  wire logic                          port1_pin_in,
   input  wire logic                          port1_overcurrent_in_n,
   // Suspend pin, two-way when swapped
   output logic                               suspend_out,
   output logic                               suspend_oe_out,
   input  wire logic                          suspend_pin_in,
   // Upstream bus power
   input  wire logic                          vbus_detect_in,
   output logic                               vbus_present_out
);

   localparam int SYNC_W = NPORTS + 3;
   // A one-cycle tick still needs a one-bit prescaler.
   localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [SYNC_W-1:0] sync_raw;
   logic [SYNC_W-1:0] sync_meta;
   logic [SYNC_W-1:0] sync_q;
   logic [NPORTS:2]   oc_n_s;
   logic              p1_oc_n_s;
   logic              p1_pin_s;
   logic              susp_pin_s;
   logic              vbus_s;

   assign sync_raw = {vbus_detect_in, suspend_pin_in, port1_pin_in,
                      port1_overcurrent_in_n, overcurrent_sense_in_n};

   // Pins may change at any time, so they pass two stages first.
   always_ff @(posedge clock_in) begin
      sync_meta <= sync_raw;
      sync_q    <= sync_meta;
   end

   assign oc_n_s     = sync_q[NPORTS-2:0];
   assign p1_oc_n_s  = sync_q[NPORTS-1];
   assign p1_pin_s   = sync_q[NPORTS];
   assign susp_pin_s = sync_q[NPORTS+1];
   assign vbus_s     = sync_q[NPORTS+2];

   // ------------------------------------------------------------
   // Millisecond timebase
   // ------------------------------------------------------------
   logic [TICK_W-1:0] presc;
   logic              tick;

   assign tick = presc == TICK_W'(TICK_CYCLES - 1);

   always_ff @(posedge clock_in) begin
      if (rst_in || tick) begin
         presc <= '0;
      end else begin
         presc <= presc + TICK_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [NPORTS:1]                   chg_en;
   hub_pp_pkg::cfg_t                  cfg;
   logic                              init_done;
   logic [NPORTS:1]                   host_req_q;
   logic                              wr_chg_en;
   logic                              wr_cfg;
   logic [hub_pp_pkg::DATA_W-1:0]     status_word;
   logic [hub_pp_pkg::DATA_W-1:0]     retry_word;
   logic [hub_pp_pkg::DATA_W-1:0]     next_read_data;

   // The charging type is fixed once initialisation ends, so the enable
   // register stops accepting writes from then on.
   assign wr_chg_en = reg_req_in.wr && !init_done
                      && reg_req_in.addr == hub_pp_pkg::ADDR_CHG_EN;
   assign wr_cfg    = reg_req_in.wr && reg_req_in.addr == hub_pp_pkg::ADDR_CFG;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         chg_en <= hub_pp_pkg::CHG_EN_RESET;
      end else if (wr_chg_en) begin
         chg_en <= reg_req_in.wdata[NPORTS:1];
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cfg <= hub_pp_pkg::cfg_t'(hub_pp_pkg::CFG_RESET);
      end else if (wr_cfg) begin
         cfg <= hub_pp_pkg::cfg_t'(reg_req_in.wdata[3:0]);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         init_done  <= 1'b0;
         host_req_q <= '0;
      end else begin
         init_done  <= init_done | hw_init_done_in;
         host_req_q <= host_port_power_in;
      end
   end

   // ------------------------------------------------------------
   // Port requests and fault qualification
   // ------------------------------------------------------------
   logic [NPORTS:1]  request;
   logic [NPORTS:1]  release_req;
   logic [NPORTS:1]  dcp;
   logic [NPORTS:1]  oc;
   logic [NPORTS:1]  fault_event;
   logic [NPORTS:1]  slot_fault;
   logic [NPORTS:1]  pwr;
   logic [NPORTS:1]  hold;
   logic [1:0]       attempts [NPORTS:1];
   logic             p1_oc_src;
   logic             any_fault;

   // Charging ports request power as soon as init ends.
   assign request     = {NPORTS{init_done}} & (chg_en | host_port_power_in);
   assign release_req = host_req_q & ~host_port_power_in;
   assign dcp         = chg_en & {NPORTS{!host_connected_in}};

   // Output enables delayed to line up with the two synchroniser stages.
   // While a combined pin was still driven low by this module, the level
   // seen is its own drive and not a fault, so it is masked.
   logic [1:0]       p1_oe_d;
   logic [1:0]       susp_oe_d;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         p1_oe_d   <= 2'h3;
         susp_oe_d <= 2'h3;
      end else begin
         p1_oe_d   <= {p1_oe_d[0], port1_power_oe_out};
         susp_oe_d <= {susp_oe_d[0], suspend_oe_out};
      end
   end

   // Port 1 sense follows whichever pin carries it in the current swap mode.
   assign p1_oc_src = !cfg.swap_en  ? !p1_oc_n_s :
                      !cfg.swap_sel ? !p1_pin_s && !p1_oe_d[1] :
                                      !susp_pin_s && !susp_oe_d[1];

   assign oc = {~oc_n_s, p1_oc_src};

   // A fault only counts on a powered port, so an unpowered port never
   // latches a stale event.
   assign fault_event = oc & pwr;
   assign any_fault   = |fault_event;
   assign slot_fault  = cfg.indiv ? fault_event : {NPORTS{any_fault}};

   // ------------------------------------------------------------
   // Per-port power slots
   // ------------------------------------------------------------
   for (genvar p = 1; p <= NPORTS; p++) begin : g_slot
      port_power_slot #(
         .MS_W (hub_pp_pkg::MS_W)
      ) u_slot (
         .clock_in     (clock_in),
         .rst_in       (rst_in),
         .tick_in      (tick),
         .request_in   (request[p]),
         .release_in   (release_req[p]),
         .dcp_in       (dcp[p]),
         .fault_in     (slot_fault[p]),
         .power_out    (pwr[p]),
         .hold_out     (hold[p]),
         .attempts_out (attempts[p])
      );
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   logic swap_plain;
   logic swap_active;
   logic susp_level;
   logic next_p1_out;
   logic next_p1_oe;
   logic next_susp_out;
   logic next_susp_oe;
   logic next_vbus;

   assign swap_plain  = cfg.swap_en && !cfg.swap_sel;
   assign swap_active = cfg.swap_en && cfg.swap_sel;

   // Only whole-hub state feeds the level; per-port suspend never reaches it.
   assign susp_level = cfg.susp_en
                       && (hub_suspended_in || !hub_configured_in);

   // Combined pins are open drain: released to enable, pulled low to disable,
   // and the external switch pulls low on a fault.
   assign next_p1_out = !cfg.swap_en ? pwr[1] : swap_active;
   assign next_p1_oe  = !swap_plain || !pwr[1];

   assign next_susp_out = !cfg.swap_en && susp_level;
   assign next_susp_oe  = !swap_active || !pwr[1];

   assign next_vbus = swap_active || vbus_s;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         port_power_enable_out  <= '0;
         port1_power_enable_out <= 1'b0;
         port1_power_oe_out     <= 1'b1;
         suspend_out            <= 1'b0;
         suspend_oe_out         <= 1'b1;
         vbus_present_out       <= 1'b0;
      end else begin
         port_power_enable_out  <= pwr[NPORTS:2];
         port1_power_enable_out <= next_p1_out;
         port1_power_oe_out     <= next_p1_oe;
         suspend_out            <= next_susp_out;
         suspend_oe_out         <= next_susp_oe;
         vbus_present_out       <= next_vbus;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      retry_word = '0;
      for (int p = 1; p <= NPORTS; p++) begin
         retry_word[2*p +: 2] = attempts[p];
      end
   end

   assign status_word =
      (hub_pp_pkg::DATA_W'({pwr, 1'b0})  << hub_pp_pkg::STAT_PWR_POS)
    | (hub_pp_pkg::DATA_W'({hold, 1'b0}) << hub_pp_pkg::STAT_HOLD_POS)
    | (hub_pp_pkg::DATA_W'({dcp, 1'b0})  << hub_pp_pkg::STAT_DCP_POS)
    | (hub_pp_pkg::DATA_W'(suspend_out)      << hub_pp_pkg::STAT_SUSP_BIT)
    | (hub_pp_pkg::DATA_W'(vbus_present_out) << hub_pp_pkg::STAT_VBUS_BIT)
    | (hub_pp_pkg::DATA_W'(init_done)        << hub_pp_pkg::STAT_INIT_BIT);

   assign next_read_data =
      !reg_req_in.rd ? '0 :
      reg_req_in.addr == hub_pp_pkg::ADDR_CHG_EN ?
         hub_pp_pkg::DATA_W'({chg_en, 1'b0}) :
      reg_req_in.addr == hub_pp_pkg::ADDR_CFG ? hub_pp_pkg::DATA_W'(cfg) :
      reg_req_in.addr == hub_pp_pkg::ADDR_STATUS ? status_word :
      reg_req_in.addr == hub_pp_pkg::ADDR_RETRY ? retry_word : '0;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         read_data_out <= '0;
      end else begin
         read_data_out <= next_read_data;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking top_cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   AST_GANG_OFF: assert property (
      !cfg.indiv && any_fault |=> pwr == '0)
      else $error("Ganged fault left a port powered.");

   AST_INDIV_KEEP: assert property (
      cfg.indiv && fault_event[NPORTS] && !fault_event[2] && pwr[2] && request[2]
      |=> pwr[2])
      else $error("Individual fault removed power from another port.");

   AST_CHG_ON: assert property (
      $rose(init_done) && chg_en[2] |=> pwr[2])
      else $error("Charging port not powered after init.");

   AST_CHG_LOCK: assert property (
      init_done && reg_req_in.wr && reg_req_in.addr == hub_pp_pkg::ADDR_CHG_EN
      |=> $stable(chg_en))
      else $error("Charging enables changed after init.");

   AST_P1_COMBINED: assert property (
      swap_plain |=> !port1_power_enable_out
                     && port1_power_oe_out == !$past(pwr[1]))
      else $error("Port 1 pin not in combined mode.");

   AST_SUSP_LOW: assert property (
      swap_plain |=> !suspend_out && suspend_oe_out)
      else $error("Suspend pin not held low with swap enabled.");

   AST_VBUS_IGNORED: assert property (
      swap_active |=> vbus_present_out)
      else $error("Bus-power detect not ignored while swapped.");

   AST_P1_FORCED: assert property (
      swap_active |=> port1_power_enable_out && port1_power_oe_out)
      else $error("Port 1 pin not forced high while swapped.");

   AST_SUSP_COMBINED: assert property (
      swap_active |=> !suspend_out && suspend_oe_out == !$past(pwr[1]))
      else $error("Suspend pin not carrying port 1 power while swapped.");

   AST_SUSP_LEVEL: assert property (
      !cfg.swap_en && cfg.susp_en
      |=> suspend_out == $past(hub_suspended_in || !hub_configured_in))
      else $error("Suspend level does not follow hub state.");

endmodule

// >>> hub_switch_model.sv
// Power switches behind the downstream and combined pins.
// Assumes the bench raises fault_in to overload a port's switch.
module hub_switch_model (
   // Fault commands
   input  wire logic [4:1] fault_in,
   // Combined pin drive
   input  wire logic       p1_out_in,
   input  wire logic       p1_oe_in,
   input  wire logic       susp_out_in,
   input  wire logic       susp_oe_in,
   // Sense lines
   output logic [4:2]      oc_n_out,
   output logic            p1_oc_n_out,
   output logic            p1_pin_out,
   output logic            susp_pin_out
);
   // Pulled up; an overloaded switch pulls a released pin low.
   assign oc_n_out     = ~fault_in[4:2];
   assign p1_oc_n_out  = ~fault_in[1];
   assign p1_pin_out   = p1_oe_in ? p1_out_in : ~fault_in[1];
   assign susp_pin_out = susp_oe_in ? susp_out_in : ~fault_in[1];
endmodule

// >>> hub_port_power_control_bench.sv
// Self-checking bench for the hub port power control block.
// Assumes the package is compiled first; a tick is one cycle here.
module hub_port_power_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk, rst, init, host, susp, conf, vbus;
   logic [4:1]           hpp, flt;
   hub_pp_pkg::reg_req_t req;
   logic [31:0]          rdat;
   logic [4:2]           pen, ocn;
   logic                 p1o, p1e, p1p, p1n, so, se, sp, vp;
   wire  [4:1]           pw = {pen, p1o};
   int                   num_errors, num_checks, n;
   hub_port_power_control #(.TICK_CYCLES(1)) u_hub_port_power_control (
      .clock_in(clk), .rst_in(rst), .reg_req_in(req), .read_data_out(rdat),
      .hw_init_done_in(init), .host_connected_in(host), .hub_suspended_in(susp),
      .hub_configured_in(conf), .host_port_power_in(hpp), .port_power_enable_out(pen),
      .overcurrent_sense_in_n(ocn), .port1_power_enable_out(p1o),
      .port1_power_oe_out(p1e), .port1_pin_in(p1p), .port1_overcurrent_in_n(p1n),
      .suspend_out(so), .suspend_oe_out(se), .suspend_pin_in(sp),
      .vbus_detect_in(vbus), .vbus_present_out(vp));
   hub_switch_model u_hub_switch_model (
      .fault_in(flt), .p1_out_in(p1o), .p1_oe_in(p1e), .susp_out_in(so),
      .susp_oe_in(se), .oc_n_out(ocn), .p1_oc_n_out(p1n), .p1_pin_out(p1p),
      .susp_pin_out(sp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(nm, e, rdat);
   endtask
   // Bounded wait for one port's enable to reach a level.
   task automatic wt(input int p, input logic v, input int lim);
      n = 0;
      while (pw[p] !== v && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      summarize();
   end
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_charge();
      rchk("cfg", hub_pp_pkg::ADDR_CFG, 32'h0000_0008);
      rchk("chg", hub_pp_pkg::ADDR_CHG_EN, 32'h0000_0000);
      rchk("hole", 8'h10, 32'h0000_0000);
      wr(hub_pp_pkg::ADDR_CHG_EN, 32'h0000_0004);
      wr(hub_pp_pkg::ADDR_CFG, 32'h0000_0009);
      @(posedge clk) init <= 1'b1;
      cyc(8);
      chk("pw", 32'h2, 32'(pw));
      rchk("stat", hub_pp_pkg::ADDR_STATUS, 32'h0504_0004);
      wr(hub_pp_pkg::ADDR_CHG_EN, 32'h0000_0008);
      rchk("chg", hub_pp_pkg::ADDR_CHG_EN, 32'h0000_0004);
      $display("charging done");
   endtask
   task automatic t_indiv();
      @(posedge clk) hpp <= 4'b1001;
      cyc(8);
      @(posedge clk) flt[4] <= 1'b1;
      cyc(8);
      chk("pw", 32'h3, 32'(pw));
      @(posedge clk) {flt, hpp} <= 8'h01;
      cyc(8);
      @(posedge clk) hpp <= 4'b1001;
      cyc(8);
      chk("pw", 32'hB, 32'(pw));
      $display("individual done");
   endtask
   task automatic t_retry();
      @(posedge clk) flt[2] <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wt(2, 1'b0, 10);
         chk("off", 32'h0, 32'(pw[2]));
         if (i == 3) @(posedge clk) flt[2] <= 1'b0;
         wt(2, 1'b1, 11000);
         chk("span", 32'h1, 32'((n - (i < 3 ? 1000 : 10000)) inside {[-8:8]}));
      end
      rchk("tries", hub_pp_pkg::ADDR_RETRY, 32'h0000_0030);
      cyc(1020);
      rchk("tries", hub_pp_pkg::ADDR_RETRY, 32'h0000_0000);
      $display("retry done");
   endtask
   task automatic t_gang();
      wr(hub_pp_pkg::ADDR_CFG, 32'h0000_0008);
      @(posedge clk) flt[4] <= 1'b1;
      cyc(8);
      chk("pw", 32'h0, 32'(pw));
      @(posedge clk) {flt, hpp} <= 8'h00;
      cyc(1020);
      @(posedge clk) hpp <= 4'b1001;
      cyc(8);
      chk("pw", 32'hB, 32'(pw));
      $display("ganged done");
   endtask
   task automatic t_swap();
      wr(hub_pp_pkg::ADDR_CFG, 32'h0000_000A);
      cyc(4);
      chk("swap", 32'h1, 32'({p1o, p1e, so, se}));
      wr(hub_pp_pkg::ADDR_CFG, 32'h0000_000E);
      cyc(4);
      chk("swap", 32'hD, 32'({p1o, p1e, se, vp}));
      $display("swap done");
   endtask
   task automatic t_susp();
      wr(hub_pp_pkg::ADDR_CFG, 32'h0000_0008);
      @(posedge clk) vbus <= 1'b1;
      cyc(4);
      chk("susp", 32'h3, 32'({so, vp}));
      @(posedge clk) {conf, hpp} <= 5'h10;
      cyc(4);
      chk("susp", 32'h0, 32'(so));
      @(posedge clk) susp <= 1'b1;
      cyc(4);
      chk("susp", 32'h1, 32'(so));
      @(posedge clk) host <= 1'b1;
      cyc(2);
      rchk("stat", hub_pp_pkg::ADDR_STATUS, 32'h0700_0004);
      $display("suspend done");
   endtask
   initial begin
      {rst, init, host, susp, conf, vbus, hpp, flt} = 14'h2000;
      req = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_charge();
      t_indiv();
      t_retry();
      t_gang();
      t_swap();
      t_susp();
      summarize();
   end
endmodule
